// >>> logic/sdi_regs_pkg.sv
// constants, field layouts and carrier types for the receiver register bank
// assumes a word-addressed 12-bit host register port with 16-bit data
package sdi_regs_pkg;
    localparam int addr_width = 12;
    localparam int data_width = 16;

    localparam logic [11:0] addr_primary_mask = 12'h037;
    localparam logic [11:0] addr_second_mask = 12'h038;
    localparam logic [11:0] addr_clock_phase = 12'h06c;
    localparam logic [11:0] addr_drive = 12'h06d;
    localparam logic [11:0] addr_tolerance = 12'h06f;
    localparam logic [11:0] addr_noise_imm = 12'h085;
    localparam logic [11:0] addr_rate_select = 12'h024;
    localparam logic [11:0] addr_raster_status = 12'h022;
    localparam logic [11:0] addr_anc_base = 12'h800;
    localparam logic [11:0] addr_anc_last = 12'hbff;
    localparam int anc_depth = 1024;
    localparam int anc_index_width = 10;

    localparam int primary_mask_width = 11;
    localparam int second_mask_width = 7;
    localparam logic [10:0] primary_mask_valid = 11'h77f;
    localparam logic [6:0] second_mask_valid = 7'h7f;
    localparam int phase_select_bit = 5;
    localparam int offset_width = 5;
    localparam int noise_imm_bit = 10;
    localparam int rate_auto_bit = 2;
    localparam int multiplier_bit = 13;

    localparam logic [1:0] upper_drive_reset = 2'h2;
    localparam logic [1:0] status_drive_reset = 2'h2;
    localparam logic [1:0] lower_drive_reset = 2'h3;
    localparam logic [3:0] tolerance_reset = 4'h2;
    localparam logic [1:0] rate_manual_reset = 2'h0;

    localparam int trs_lock_count = 3;
    localparam logic [3:0] trs_lock_reset = 4'h0;

    typedef struct packed {
        logic [1:0] upper_data_drive_code;
        logic [1:0] status_pin_drive_code;
        logic [1:0] lower_data_drive_code;
    } drive_type;

    typedef struct packed {
        logic ddr_clock_phase_select;
        logic [4:0] output_delay_offset;
        drive_type drive;
        logic [3:0] tolerance;
        logic strict_lock_enable;
        logic rate_detect_auto_select;
        logic [1:0] rate_manual;
    } config_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [11:0] address;
        logic [15:0] write_data;
    } host_request_type;

    typedef struct packed {
        logic primary_end_active_error;
        logic primary_start_active_error;
        logic primary_line_number_error;
        logic primary_luma_crc_error;
        logic primary_chroma_crc_error;
        logic primary_luma_checksum_error;
        logic primary_chroma_checksum_error;
        logic active_picture_crc_error;
        logic full_field_crc_error;
        logic primary_video_standard_error;
        logic second_end_active_error;
        logic second_start_active_error;
        logic second_line_number_error;
        logic second_luma_crc_error;
        logic second_chroma_crc_error;
        logic second_luma_checksum_error;
        logic second_chroma_checksum_error;
    } error_type;

    typedef enum logic [1:0] {
        lock_idle = 2'b00,
        lock_first = 2'b01,
        lock_second = 2'b11,
        lock_held = 2'b10
    } lock_state_type;
endpackage : sdi_regs_pkg

// >>> logic/anc_window.sv
// ancillary data store behind the read-only host window
// assumes the extractor writes one byte pair per strobe on the same clock
module anc_window
    import sdi_regs_pkg::*;
#(
    parameter int depth = anc_depth,
    parameter int index_width = anc_index_width
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic store,
    input wire logic [index_width-1:0] store_index,
    input wire logic [7:0] store_high,
    input wire logic [7:0] store_low,
    input wire logic [index_width-1:0] read_index,
    output logic [15:0] read_data
);
    typedef struct packed {
        logic [depth-1:0] written;
        logic [15:0] read_data;
    } state_type;

    logic [15:0] words [depth];
    state_type state;
    state_type next_state;

    // a valid bit per word makes every location read zero after reset
    // without clearing the whole array
    always_comb begin
        next_state = state;
        if (store) begin
            next_state.written[store_index] = 1'b1;
        end
        next_state.read_data = state.written[read_index] ? words[read_index] : 16'h0000;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (store) begin
            words[store_index] <= {store_high, store_low};
        end
    end

    assign read_data = state.read_data;
endmodule : anc_window

// >>> logic/strict_lock.sv
// video lock qualifier with optional noise immunity
// assumes trs detections arrive as one-cycle strobes with their alignment
module strict_lock
    import sdi_regs_pkg::*;
#(
    parameter int align_width = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strict_enable,
    input wire logic trs_found,
    input wire logic [align_width-1:0] trs_alignment,
    input wire logic signal_lost,
    output logic video_locked
);
    typedef struct packed {
        lock_state_type phase;
        logic [align_width-1:0] last_alignment;
    } state_type;

    state_type state;
    state_type next_state;

    always_comb begin
        next_state = state;
        if (signal_lost) begin
            next_state.phase = lock_idle;
        end else if (trs_found) begin
            next_state.last_alignment = trs_alignment;
            case (state.phase)
                lock_idle: begin
                    next_state.phase = strict_enable ? lock_first : lock_held;
                end
                lock_first: begin
                    next_state.phase = lock_second;
                end
                lock_second: begin
                    // third word must match the second one's alignment
                    if (trs_alignment == state.last_alignment) begin
                        next_state.phase = lock_held;
                    end
                end
                lock_held: begin
                    next_state.phase = lock_held;
                end
                default: begin
                    next_state.phase = lock_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '{phase: lock_idle, last_alignment: '0};
        end else begin
            state <= next_state;
        end
    end

    assign video_locked = (state.phase == lock_held);
endmodule : strict_lock

// >>> logic/sdi_rx_error_mask_and_config_regs.sv
// host register bank: error masks, output clock and drive, rate detect, lock, anc window
// assumes a synchronous host port on clk; errors are same-clock one-cycle flags
module sdi_rx_error_mask_and_config_regs
    import sdi_regs_pkg::*;
#(
    parameter int align_width = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire host_request_type host_request,
    output logic [15:0] read_data,
    output logic read_valid,
    input wire error_type errors,
    input wire logic rate_multiplier_1001,
    input wire logic trs_found,
    input wire logic [align_width-1:0] trs_alignment,
    input wire logic signal_lost,
    input wire logic anc_store,
    input wire logic [anc_index_width-1:0] anc_store_index,
    input wire logic [7:0] anc_store_high,
    input wire logic [7:0] anc_store_low,
    output logic global_error,
    output logic [16:0] global_error_vector,
    output logic video_locked,
    output config_type config_out
);
    typedef struct packed {
        logic [10:0] primary_mask;
        logic [6:0] second_mask;
        config_type cfg;
        logic [15:0] read_data;
        logic read_valid;
        logic anc_pending;
        logic [16:0] error_vector;
        logic global_error;
        logic video_locked;
    } state_type;

    state_type state;
    state_type next_state;
    logic [15:0] anc_word;
    logic anc_hit;
    logic raw_locked;
    logic [16:0] raw_errors;
    logic [16:0] mask_bits;

    function automatic logic in_anc(input logic [11:0] address);
        in_anc = (address >= addr_anc_base) && (address <= addr_anc_last);
    endfunction : in_anc

    anc_window #(
        .depth(anc_depth),
        .index_width(anc_index_width)
    ) u_anc (
        .clk(clk),
        .rst_n(rst_n),
        .store(anc_store),
        .store_index(anc_store_index),
        .store_high(anc_store_high),
        .store_low(anc_store_low),
        .read_index(host_request.address[anc_index_width-1:0]),
        .read_data(anc_word)
    );

    strict_lock #(
        .align_width(align_width)
    ) u_lock (
        .clk(clk),
        .rst_n(rst_n),
        .strict_enable(state.cfg.strict_lock_enable),
        .trs_found(trs_found),
        .trs_alignment(trs_alignment),
        .signal_lost(signal_lost),
        .video_locked(raw_locked)
    );

    // error_type runs opposite to the mask layout (bit 16 pairs with mask bit 0), so mask_bits is reversed, bit 7 skipped
    assign raw_errors = errors;
    assign mask_bits = {state.primary_mask[0], state.primary_mask[1], state.primary_mask[2],
                        state.primary_mask[3], state.primary_mask[4], state.primary_mask[5],
                        state.primary_mask[6], state.primary_mask[8], state.primary_mask[9],
                        state.primary_mask[10], state.second_mask[0], state.second_mask[1],
                        state.second_mask[2], state.second_mask[3], state.second_mask[4],
                        state.second_mask[5], state.second_mask[6]};

    assign anc_hit = in_anc(host_request.address);

    always_comb begin
        next_state = state;
        next_state.read_valid = 1'b0;
        next_state.error_vector = raw_errors & ~mask_bits;
        next_state.global_error = |(raw_errors & ~mask_bits);
        next_state.video_locked = raw_locked;
        if (host_request.write) begin
            // reserved bits are dropped at the write so they always read zero
            case (host_request.address)
                addr_primary_mask: begin
                    next_state.primary_mask =
                        host_request.write_data[primary_mask_width-1:0]
                        & primary_mask_valid;
                end
                addr_second_mask: begin
                    next_state.second_mask =
                        host_request.write_data[second_mask_width-1:0]
                        & second_mask_valid;
                end
                addr_clock_phase: begin
                    next_state.cfg.ddr_clock_phase_select =
                        host_request.write_data[phase_select_bit];
                    next_state.cfg.output_delay_offset =
                        host_request.write_data[offset_width-1:0];
                end
                addr_drive: begin
                    next_state.cfg.drive = host_request.write_data[5:0];
                end
                addr_tolerance: begin
                    next_state.cfg.tolerance = host_request.write_data[3:0];
                end
                addr_noise_imm: begin
                    next_state.cfg.strict_lock_enable =
                        host_request.write_data[noise_imm_bit];
                end
                addr_rate_select: begin
                    next_state.cfg.rate_detect_auto_select =
                        host_request.write_data[rate_auto_bit];
                    next_state.cfg.rate_manual = host_request.write_data[1:0];
                end
                default: begin
                    next_state.cfg = state.cfg;
                end
            endcase
        end
        // the anc store answers one cycle late, so its read completes a cycle later
        if (state.anc_pending) begin
            next_state.read_data = anc_word;
            next_state.read_valid = 1'b1;
            next_state.anc_pending = 1'b0;
        end else if (host_request.read && anc_hit) begin
            next_state.anc_pending = 1'b1;
        end else if (host_request.read) begin
            next_state.read_valid = 1'b1;
            case (host_request.address)
                addr_primary_mask: begin
                    next_state.read_data = {5'h00, state.primary_mask};
                end
                addr_second_mask: begin
                    next_state.read_data = {9'h000, state.second_mask};
                end
                addr_clock_phase: begin
                    next_state.read_data = {10'h000, state.cfg.ddr_clock_phase_select,
                                            state.cfg.output_delay_offset};
                end
                addr_drive: begin
                    next_state.read_data = {10'h000, state.cfg.drive};
                end
                addr_tolerance: begin
                    next_state.read_data = {12'h000, state.cfg.tolerance};
                end
                addr_noise_imm: begin
                    next_state.read_data = {5'h00, state.cfg.strict_lock_enable, 10'h000};
                end
                addr_rate_select: begin
                    next_state.read_data = {13'h0000, state.cfg.rate_detect_auto_select,
                                            state.cfg.rate_manual};
                end
                addr_raster_status: begin
                    next_state.read_data = 16'h0000;
                    next_state.read_data[multiplier_bit] = rate_multiplier_1001;
                end
                default: begin
                    next_state.read_data = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
            state.cfg.drive.upper_data_drive_code <= upper_drive_reset;
            state.cfg.drive.status_pin_drive_code <= status_drive_reset;
            state.cfg.drive.lower_data_drive_code <= lower_drive_reset;
            state.cfg.tolerance <= tolerance_reset;
            state.cfg.rate_detect_auto_select <= 1'b1;
            state.cfg.rate_manual <= rate_manual_reset;
        end else begin
            state <= next_state;
        end
    end

    assign read_data = state.read_data;
    assign read_valid = state.read_valid;
    assign global_error = state.global_error;
    assign global_error_vector = state.error_vector;
    assign video_locked = state.video_locked;
    assign config_out = state.cfg;
endmodule : sdi_rx_error_mask_and_config_regs

// >>> verification/sdi_regs_checker_sva.sv
// concurrent checks on the receiver register bank ports
// assumes the bank sits on one clock with a synchronous active-low reset
module sdi_regs_checker
    import sdi_regs_pkg::*;
#(
    parameter int align_width = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire host_request_type host_request,
    input wire logic [15:0] read_data,
    input wire logic read_valid,
    input wire error_type errors,
    input wire logic global_error,
    input wire logic [16:0] global_error_vector,
    input wire logic video_locked,
    input wire config_type config_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic anc_rd;
    logic reg_rd;
    logic [15:0] wd_q;
    logic [11:0] adr;
    assign adr = host_request.address;
    assign anc_rd = host_request.read && adr >= addr_anc_base && adr <= addr_anc_last;
    assign reg_rd = host_request.read && adr < addr_anc_base;
    always_ff @(posedge clk) begin
        wd_q <= host_request.write_data;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a read taken the cycle after a window read meets the pending answer and is dropped
    reserved_zero_a: assert property (reg_rd && adr >= 12'h039 && adr <= 12'h06b
        && !$past(anc_rd) |=> read_valid && read_data == 16'h0000) else $error("reserved read");
    anc_answer_a: assert property (anc_rd && !$past(anc_rd) |-> ##2 read_valid)
        else $error("window read not answered");
    mask_reserved_a: assert property (reg_rd && adr == addr_primary_mask && !$past(anc_rd)
        |=> read_valid && read_data[15:11] == 5'h00 && !read_data[7]) else $error("mask1 spare");
    second_spare_a: assert property (reg_rd && adr == addr_second_mask && !$past(anc_rd)
        |=> read_valid && read_data[15:7] == 9'h000) else $error("mask2 spare");
    vector_subset_a: assert property ((global_error_vector & ~$past(errors)) == 17'h00000)
        else $error("vector bit without error");
    global_or_a: assert property (global_error == (|global_error_vector))
        else $error("global error mismatch");
    phase_write_a: assert property (host_request.write && adr == addr_clock_phase |=>
        config_out.ddr_clock_phase_select == wd_q[5]
        && config_out.output_delay_offset == wd_q[4:0]) else $error("clock phase write");
    drive_write_a: assert property (host_request.write && adr == addr_drive
        |=> config_out.drive == wd_q[5:0]) else $error("drive write");
    tolerance_write_a: assert property (host_request.write && adr == addr_tolerance
        |=> config_out.tolerance == wd_q[3:0]) else $error("tolerance write");
    strict_write_a: assert property (host_request.write && adr == addr_noise_imm
        |=> config_out.strict_lock_enable == wd_q[10]) else $error("strict lock write");
    config_hold_a: assert property (!host_request.write |=> $stable(config_out))
        else $error("config changed without write");
    reset_value_a: assert property ($rose(rst_n) |-> config_out.drive == 6'h2b
        && config_out.tolerance == 4'h2 && config_out.rate_detect_auto_select
        && !config_out.strict_lock_enable && config_out.output_delay_offset == 5'h00)
        else $error("reset values");
    cover property (anc_rd ##2 read_valid);
    cover property ($rose(video_locked));
    cover property (global_error);
    cover property (host_request.write && adr == addr_noise_imm);
endmodule : sdi_regs_checker

bind sdi_rx_error_mask_and_config_regs sdi_regs_checker #(.align_width(align_width))
    u_sdi_regs_checker (.clk(clk), .rst_n(rst_n), .host_request(host_request),
    .read_data(read_data), .read_valid(read_valid), .errors(errors),
    .global_error(global_error), .global_error_vector(global_error_vector),
    .video_locked(video_locked), .config_out(config_out));

// >>> verification/host_model.sv
// host processor model: single-cycle write and read strobes on the register port
// assumes the caller is a bench process on the same clock
module host_model
    import sdi_regs_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] read_data,
    input wire logic read_valid,
    output host_request_type host_request
);
    timeunit 1ns;
    timeprecision 1ns;
    initial host_request = '0;
    // released fields carry the inverse so nothing leans on a stale value
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        host_request.write <= 1'b1;
        host_request.address <= a;
        host_request.write_data <= d;
        @(posedge clk);
        host_request.write <= 1'b0;
        host_request.address <= ~a;
        host_request.write_data <= ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        int i;
        logic got;
        got = 1'b0;
        d = 16'hxxxx;
        @(posedge clk);
        host_request.read <= 1'b1;
        host_request.address <= a;
        @(posedge clk);
        host_request.read <= 1'b0;
        host_request.address <= ~a;
        for (i = 0; i < 4 && !got; i++) begin
            #1;
            if (read_valid === 1'b1) begin
                d = read_data;
                got = 1'b1;
            end else begin
                @(posedge clk);
            end
        end
    endtask : rd
endmodule : host_model

// >>> verification/test_sdi_rx_error_mask_and_config_regs.sv
// self-checking bench for the receiver register bank with a reference model
// assumes host_model drives the register port; bench drives detector inputs
module test_sdi_rx_error_mask_and_config_regs
    import sdi_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, read_valid, rate_multiplier_1001, trs_found, signal_lost, anc_store;
    logic global_error, video_locked;
    logic [15:0] read_data, d, wd;
    logic [16:0] global_error_vector, prev, ev;
    logic [3:0] trs_alignment;
    logic [9:0] anc_store_index;
    logic [7:0] anc_store_high, anc_store_low;
    host_request_type host_request;
    error_type errors;
    config_type config_out;
    int error_cnt = 0, total_checks = 0, seed = 67664, i, b, n;
    logic [11:0] ra [10] = '{12'h037, 12'h038, 12'h06c, 12'h06d, 12'h06f, 12'h085, 12'h024,
        12'h039, 12'h06e, 12'h100};
    logic [15:0] rm [10] = '{16'h077f, 16'h007f, 16'h003f, 16'h003f, 16'h000f, 16'h0400,
        16'h0007, 16'h0, 16'h0, 16'h0};
    logic [15:0] rr [10] = '{16'h0, 16'h0, 16'h0, 16'h002b, 16'h0002, 16'h0, 16'h0004,
        16'h0, 16'h0, 16'h0};
    logic [15:0] sh [10];
    logic [15:0] anc_m [int];
    int lk [4][6] = '{'{0, 1, 2, 0, 0, 1}, '{1, 3, 1, 5, 5, 1}, '{1, 3, 3, 3, 6, 0},
        '{1, 2, 4, 4, 0, 0}};
    int ax [4] = '{0, 5, 1023, 7};
    sdi_rx_error_mask_and_config_regs u_sdi_rx_error_mask_and_config_regs (.clk(clk),
        .rst_n(rst_n), .host_request(host_request), .read_data(read_data),
        .read_valid(read_valid), .errors(errors), .rate_multiplier_1001(rate_multiplier_1001),
        .trs_found(trs_found), .trs_alignment(trs_alignment), .signal_lost(signal_lost),
        .anc_store(anc_store), .anc_store_index(anc_store_index),
        .anc_store_high(anc_store_high), .anc_store_low(anc_store_low),
        .global_error(global_error), .global_error_vector(global_error_vector),
        .video_locked(video_locked), .config_out(config_out));
    host_model u_host_model (.clk(clk), .read_data(read_data), .read_valid(read_valid),
        .host_request(host_request));
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bits(input string nm, input logic [16:0] e, input logic [16:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_bits
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    // vector is msb first: primary fields at 16..7, second stream at 6..0
    function automatic logic [16:0] exp_vec(input logic [16:0] e, input logic [15:0] m1,
        input logic [15:0] m2);
        logic [16:0] v;
        int k;
        v = e;
        for (k = 0; k < 10; k++) if (m1[k < 7 ? k : k + 1]) v[16-k] = 1'b0;
        for (k = 0; k < 7; k++) if (m2[k]) v[6-k] = 1'b0;
        return v;
    endfunction : exp_vec
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        {rst_n, rate_multiplier_1001, trs_found, signal_lost, anc_store} = '0;
        errors = '0;
        trs_alignment = '0;
        {anc_store_index, anc_store_high, anc_store_low} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 10; i++) begin
            sh[i] = rr[i];
            u_host_model.rd(ra[i], d);
            chk_word("reset value", rr[i], d);
        end
        for (b = 0; b < 3; b++) for (i = 0; i < 10; i++) begin
            wd = (b == 1) ? 16'hffff : $random(seed);
            u_host_model.wr(ra[i], wd);
            sh[i] = wd & rm[i];
            u_host_model.rd(ra[i], d);
            chk_word("readback", sh[i], d);
        end
        for (b = 0; b < 2; b++) begin
            @(posedge clk) rate_multiplier_1001 <= b[0];
            u_host_model.rd(addr_raster_status, d);
            chk_bits("multiplier status", {16'h0, b[0]}, {16'h0, d[multiplier_bit]});
        end
        u_host_model.wr(addr_rate_select, 16'h0004);
        for (b = 0; b < 5; b++) begin
            sh[0] = (b == 0) ? 16'h0 : (b == 1) ? rm[0] : $random(seed) & rm[0];
            sh[1] = (b == 0) ? 16'h0 : (b == 1) ? rm[1] : $random(seed) & rm[1];
            u_host_model.wr(ra[0], sh[0]);
            u_host_model.wr(ra[1], sh[1]);
            prev = errors;
            for (n = 0; n < 20; n++) begin
                @(posedge clk) errors <= (b == 1) ? 17'h1ffff : 17'($random(seed));
                #1;
                ev = exp_vec(prev, sh[0], sh[1]);
                chk_bits("error vector", ev, global_error_vector);
                chk_bits("global error", {16'h0, |ev}, {16'h0, global_error});
                prev = errors;
            end
        end
        for (b = 0; b < 4; b++) begin
            u_host_model.wr(addr_noise_imm, lk[b][0] ? 16'h0400 : 16'h0000);
            for (n = 0; n < lk[b][1]; n++) begin
                @(posedge clk);
                trs_found <= 1'b1;
                trs_alignment <= lk[b][2+n];
            end
            @(posedge clk) trs_found <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chk_bits("video lock", {16'h0, lk[b][5][0]}, {16'h0, video_locked});
            @(posedge clk) signal_lost <= 1'b1;
            repeat (2) @(posedge clk);
            signal_lost <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chk_bits("lock after loss", 17'h0, {16'h0, video_locked});
        end
        for (i = 0; i < 3; i++) begin
            wd = $random(seed);
            @(posedge clk);
            anc_store <= 1'b1;
            anc_store_index <= ax[i];
            anc_store_high <= wd[15:8];
            anc_store_low <= wd[7:0];
            anc_m[ax[i]] = wd;
            @(posedge clk) anc_store <= 1'b0;
        end
        for (i = 0; i < 4; i++) begin
            u_host_model.rd(addr_anc_base + ax[i], d);
            chk_word("anc word", anc_m.exists(ax[i]) ? anc_m[ax[i]] : 16'h0, d);
        end
        stop_test();
    end
endmodule : test_sdi_rx_error_mask_and_config_regs
